// ===== rtl/sarsc_fifo.sv
// Result FIFO between the conversion engine and the parallel result port.
`timescale 1ns/1ns
module sarsc_fifo #(
    parameter int WIDTH = sarsc_pkg::FIFO_WIDTH,
    parameter int DEPTH = sarsc_pkg::FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    import sarsc_pkg::*;
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] cnt;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
    } sarsc_fifo_st_t;

    sarsc_fifo_st_t q;
    sarsc_fifo_st_t next_q;
    logic push;
    logic pop;

    assign in_ready_o = (q.cnt != FULL_CNT);
    assign out_valid_o = (q.cnt != '0);
    assign out_data_o = q.mem[q.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        next_q = q;
        if (push) begin
            next_q.mem[q.wp] = in_data_i;
            next_q.wp = (q.wp == LAST_IDX) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            next_q.rp = (q.rp == LAST_IDX) ? '0 : q.rp + 1'b1;
        end
        if (push && !pop) begin
            next_q.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            next_q.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule

// ===== rtl/sarsc_top.sv
// Serial command decoder, conversion sequencer and result shifter of the converter.
`timescale 1ns/1ns
//
// Contract
// RQ1 - Ignore serial input until a high bit; that bit is command bit 7.
// RQ2 - Command: channel bits 6-4, constant one bit 3, input mode 2, power mode 1-0.
// RQ3 - Single-ended codes 001,101,010,110 put inputs 0..3 positive, common negative.
// RQ4 - Differential: 001 in0+/in1-, 101 reverse, 010 in2+/in3-, 110 reverse.
// RQ5 - Power mode 00 auto power-down, 10 internal clock, 01 reserved, 11 always on.
// RQ6 - Auto mode powers down after conversions, powers up instantly at next start.
// RQ7 - The host shift clock shifts commands in and results out in both modes.
// RQ8 - A clock mode change takes effect one conversion after it is written.
// RQ9 - Host should write the power mode before the first conversion.
// RQ10 - External mode: status high one shift period after the last command bit.
// RQ11 - External mode: decisions on the next 16 falling edges, MSB first.
// RQ12 - External mode: host gives at least 25 clocks per conversion.
// RQ13 - Next command may overlap the LSB output for 24 clocks per conversion.
// RQ14 - Output zeros after the result bits when the host keeps clocking.
// RQ15 - External mode: outputs float while select high; status low after select falls.
// RQ16 - Internal mode: status low during conversion, high at completion, within 8 us; a full result FIFO delays completion.
// RQ17 - Internal mode: result held for readout at any later time.
// RQ18 - Internal mode, select low at completion: next falling edge gives MSB.
// RQ19 - Internal mode: output floats until select falls; conversion ignores select.
// RQ20 - Internal mode: status output is driven even while select is high.
// RQ21 - Host should hold the shift clock low during internal conversions.
// RQ22 - Fast shifting only if the host keeps acquisition above 1.7 us.
// RQ23 - Acquire once the mux is known, hold and convert three clocks later; acquisition opens at the fifth bit, the mux decodes at the sixth.
// RQ24 - Result is two's complement, passed through from the core unchanged.
// RQ25 - Select going high discards a partial command and rearms start search.
module sarsc_top (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic cs_n_i,
    input wire logic shift_clock_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    output logic busy_o,
    output logic busy_oe_o,
    input wire logic [15:0] conv_code_i,
    output sarsc_pkg::sarsc_mux_t mux_o,
    output logic acquire_o,
    output logic converter_on_o,
    output logic [15:0] result_data_o,
    output logic result_valid_o,
    input wire logic result_ready_i
);
    import sarsc_pkg::*;

    // All state lives in this one record so that reset and the next-state copy stay complete.
    // Fields are grouped by job: synchronisers, receiver, sequencer, shifter and outputs.
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] lvl;
        logic [3:0] rx_cnt;
        logic [6:0] rx_sh;
        logic [1:0] pd;
        logic int_mode;
        sarsc_eng_t eng;
        logic [8:0] tmr;
        logic [15:0] code;
        logic [15:0] sh;
        logic [4:0] sh_cnt;
        logic sh_armed;
        logic dout;
        logic busy;
        logic acq;
        logic conv_on;
        sarsc_mux_t mux;
        logic [15:0] push_data;
        logic push_v;
    } sarsc_state_t;

    sarsc_state_t q;
    sarsc_state_t next_q;
    logic fifo_in_ready;

    // Maps the channel code and input mode onto the multiplexer switches.
    // Unlisted channel codes leave every switch open rather than guessing a pairing.
    function automatic sarsc_mux_t mux_decode(input logic [2:0] ch, input logic single);
        sarsc_mux_t m;
        m = '0;
        if (single) begin
            m.com_neg = 1'b1;
            case (ch)
                CH_CODE_0: m.pos = 4'h1; // see RQ3
                CH_CODE_1: m.pos = 4'h2;
                CH_CODE_2: m.pos = 4'h4;
                CH_CODE_3: m.pos = 4'h8;
                default: m.com_neg = 1'b0;
            endcase
        end else begin
            case (ch)
                CH_CODE_0: begin // see RQ4
                    m.pos = 4'h1;
                    m.neg = 4'h2;
                end
                CH_CODE_1: begin
                    m.pos = 4'h2;
                    m.neg = 4'h1;
                end
                CH_CODE_2: begin
                    m.pos = 4'h4;
                    m.neg = 4'h8;
                end
                CH_CODE_3: begin
                    m.pos = 4'h8;
                    m.neg = 4'h4;
                end
                default: m = '0;
            endcase
        end
        return m;
    endfunction

    always_comb begin
        logic [2:0] lvl_n;
        logic cs_high;
        logic rise;
        logic fall;
        logic cs_fall;
        logic din;
        logic [7:0] cmd;
        // Locals start from fixed values so that no path leaves one undriven.
        lvl_n = '0;
        cs_high = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        cs_fall = 1'b0;
        din = 1'b0;
        cmd = '0;
        next_q = q;
        // Three-stage pin synchronisers; a level counts once stages two and three agree.
        next_q.s1 = {cs_n_i, shift_clock_i, din_i};
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        for (int i = 0; i < 3; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                next_q.lvl[i] = q.s3[i];
            end
        end
        lvl_n = next_q.lvl;
        cs_high = lvl_n[LN_CS];
        din = lvl_n[LN_DIN];
        // Shift clock edges only count while select is low.
        rise = !q.lvl[LN_SCLK] && lvl_n[LN_SCLK] && !cs_high; // see RQ7
        fall = q.lvl[LN_SCLK] && !lvl_n[LN_SCLK] && !cs_high;
        cs_fall = q.lvl[LN_CS] && !cs_high;
        cmd = {1'b1, q.rx_sh[5:0], din};

        // Command receiver.
        // The start bit is the first high level seen with select low; leading lows are skipped.
        // Acquisition opens after the fifth bit, once the channel bits are known.
        if (cs_high) begin
            next_q.rx_cnt = '0; // see RQ25
            next_q.acq = 1'b0;
        end else if (rise) begin
            if (q.rx_cnt == '0) begin
                if (din) begin
                    next_q.rx_cnt = 4'h1; // see RQ1
                end
            end else begin
                next_q.rx_sh = {q.rx_sh[5:0], din};
                next_q.rx_cnt = q.rx_cnt + 4'h1;
                if (q.rx_cnt == RX_CNT_ACQ) begin
                    next_q.acq = 1'b1; // see RQ23
                end
                if (q.rx_cnt == RX_CNT_MUX) begin
                    next_q.mux = mux_decode(next_q.rx_sh[4:2], next_q.rx_sh[0]);
                end
            end
        end

        // Result shifter: one bit per falling edge, then zeros.
        // Once the sixteen result bits are out the line stays low until the next result loads.
        if (fall && q.sh_armed) begin
            if (q.sh_cnt < RES_CNT) begin
                next_q.dout = q.sh[RES_BITS-1]; // see RQ11, RQ18
                next_q.sh = {q.sh[RES_BITS-2:0], 1'b0};
                next_q.sh_cnt = q.sh_cnt + 5'h01;
            end else begin
                next_q.dout = 1'b0; // see RQ14
            end
        end

        if (q.push_v && fifo_in_ready) begin
            next_q.push_v = 1'b0;
        end

        // External mode status returns low once select falls.
        if (cs_fall && !q.int_mode) begin
            next_q.busy = 1'b0; // see RQ15
        end

        // Conversion sequencer.
        // External conversions are paced by the host clock, internal ones by the local timer.
        // An abort by select only affects external conversions; the timer ignores the pin.
        case (q.eng)
            ENG_EXT_WAIT: begin
                if (cs_high) begin
                    next_q.eng = ENG_IDLE;
                    next_q.busy = 1'b0;
                end else if (fall) begin
                    // MSB decision period; the code is latched, shifting starts next edge.
                    next_q.busy = 1'b1; // see RQ10
                    next_q.sh = q.code; // see RQ24
                    next_q.sh_cnt = '0;
                    next_q.sh_armed = 1'b1;
                    next_q.push_data = q.code;
                    next_q.push_v = 1'b1;
                    next_q.eng = ENG_EXT_SHIFT;
                end
            end
            ENG_EXT_SHIFT: begin
                if (cs_high) begin
                    next_q.eng = ENG_IDLE;
                    next_q.busy = 1'b0;
                end else if (fall) begin
                    next_q.busy = 1'b0; // see RQ10
                    next_q.eng = ENG_IDLE;
                end
            end
            ENG_INT_RUN: begin
                // Select is not looked at here, so the conversion survives it rising.
                if (q.tmr != INT_CONV_LAST) begin
                    next_q.tmr = q.tmr + 9'h001; // see RQ16, RQ19
                end else if (!q.push_v) begin
                    // A full result FIFO stalls completion rather than losing a word.
                    next_q.busy = 1'b1; // see RQ16
                    next_q.sh = q.code; // see RQ17
                    next_q.sh_cnt = '0;
                    next_q.sh_armed = 1'b1;
                    next_q.push_data = q.code;
                    next_q.push_v = 1'b1;
                    next_q.eng = ENG_IDLE;
                end
            end
            default: begin
            end
        endcase

        // Command completion: hold the sample and start the conversion.
        // A command that arrives during the previous LSB simply restarts the sequencer here.
        if (!cs_high && rise && q.rx_cnt == RX_CNT_LAST) begin
            next_q.rx_cnt = '0;
            next_q.acq = 1'b0; // see RQ23
            next_q.code = conv_code_i;
            next_q.mux = mux_decode(cmd[CH_MSB:CH_LSB], cmd[MODE_BIT]); // see RQ2
            // The mode in force is the one written by the previous command.
            next_q.int_mode = (q.pd == PD_INTCLK); // see RQ8
            next_q.pd = cmd[PD_MSB:PD_LSB]; // see RQ5
            next_q.sh_armed = 1'b0;
            if (q.pd == PD_INTCLK) begin
                next_q.eng = ENG_INT_RUN;
                next_q.tmr = '0;
                next_q.busy = 1'b0; // see RQ16
            end else begin
                next_q.eng = ENG_EXT_WAIT; // see RQ13
            end
        end

        // Auto and reserved modes keep the core off outside acquisition and conversion.
        next_q.conv_on = (next_q.pd == PD_FULL) || next_q.acq || (next_q.eng != ENG_IDLE); // see RQ6
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Select and its stages reset high, its idle level, so no false select edge
            // follows reset and the serial outputs stay released until select is seen low.
            q <= '0;
            q.s1[LN_CS] <= 1'b1;
            q.s2[LN_CS] <= 1'b1;
            q.s3[LN_CS] <= 1'b1;
            q.lvl[LN_CS] <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // The buffer decouples the parallel result port from the serial readout, so a slow
    // consumer delays internal completions but never corrupts the serial link.
    sarsc_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .in_data_i(q.push_data),
        .in_valid_i(q.push_v),
        .in_ready_o(fifo_in_ready),
        .out_data_o(result_data_o),
        .out_valid_o(result_valid_o),
        .out_ready_i(result_ready_i)
    );

    // The enables follow the synchronised select level, so they release a few system clocks
    // after the pin rises; the status enable stays on after an internal conversion.
    assign dout_o = q.dout;
    assign dout_oe_o = !q.lvl[LN_CS]; // see RQ15, RQ19
    assign busy_o = q.busy;
    assign busy_oe_o = q.int_mode || !q.lvl[LN_CS]; // see RQ15, RQ20
    assign mux_o = q.mux;
    assign acquire_o = q.acq;
    assign converter_on_o = q.conv_on;
endmodule

// ===== shared/sarsc_pkg.sv
// Package holding constants and types of the converter serial control block.
package sarsc_pkg;
    // Command byte layout.
    localparam int CMD_BITS = 8;
    localparam int CH_MSB = 6;
    localparam int CH_LSB = 4;
    localparam int CONST_BIT = 3;
    localparam int MODE_BIT = 2;
    localparam int PD_MSB = 1;
    localparam int PD_LSB = 0;
    localparam int RES_BITS = 16;

    // Receive counter values before the edge that brings the 5th, 6th and 8th bit.
    localparam logic [3:0] RX_CNT_ACQ = 4'h4;
    localparam logic [3:0] RX_CNT_MUX = 4'h5;
    localparam logic [3:0] RX_CNT_LAST = 4'h7;
    localparam logic [4:0] RES_CNT = 5'h10;

    // Power mode codes.
    localparam logic [1:0] PD_AUTO = 2'h0;
    localparam logic [1:0] PD_RSVD = 2'h1;
    localparam logic [1:0] PD_INTCLK = 2'h2;
    localparam logic [1:0] PD_FULL = 2'h3;

    // Channel select codes for input 0 to 3.
    localparam logic [2:0] CH_CODE_0 = 3'h1;
    localparam logic [2:0] CH_CODE_1 = 3'h5;
    localparam logic [2:0] CH_CODE_2 = 3'h2;
    localparam logic [2:0] CH_CODE_3 = 3'h6;

    // Internal conversion time; a longest time, so the cycle count rounds down.
    localparam int CLK_PERIOD_NS = 20;
    localparam int INT_CONV_MAX_NS = 8000;
    localparam int INT_CONV_CYCLES = INT_CONV_MAX_NS / CLK_PERIOD_NS;
    localparam logic [8:0] INT_CONV_LAST = 9'(INT_CONV_CYCLES - 1);

    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 4;

    // Synchroniser lane positions.
    localparam int LN_DIN = 0;
    localparam int LN_SCLK = 1;
    localparam int LN_CS = 2;

    typedef struct packed {
        logic [3:0] pos;
        logic [3:0] neg;
        logic com_neg;
    } sarsc_mux_t;

    typedef enum logic [1:0] {ENG_IDLE, ENG_EXT_WAIT, ENG_EXT_SHIFT, ENG_INT_RUN} sarsc_eng_t;
endpackage

// ===== sim/sarsc_host.sv
// Host serial port model driving select, shift clock and command bits.
`timescale 1ns/1ns
module sarsc_host (
    input wire logic mclk_i,
    input wire logic dout_i,
    input wire logic dout_oe_i,
    output logic cs_n_o = 1'b1,
    output logic sclk_o = 1'b0,
    output logic din_o = 1'b0
);
    logic smp;
    // Sampling on the falling edge keeps the read clear of the edge where dout moves.
    always @(negedge mclk_i) smp <= dout_oe_i ? dout_i : 1'bz;
    task automatic half();
        repeat (4) @(posedge mclk_i);
    endtask
    // Bits leave MSB first from bits[31]; got collects dout after each fall.
    task automatic frame(input logic [31:0] bits, input int acq, input int n,
                         output logic [31:0] got);
        got = '0;
        cs_n_o <= 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            din_o <= bits[31-i];
            half();
            if (i >= acq + 5 && i <= acq + 7) begin
                repeat (30) @(posedge mclk_i);
            end
            sclk_o <= 1'b1;
            half();
            got = {got[30:0], smp};
            sclk_o <= 1'b0;
        end
        half();
        half();
        got = {got[30:0], smp};
    endtask
    // A released data line toggles so that a stale level never reads as valid.
    task automatic deselect();
        cs_n_o <= 1'b1;
        din_o <= ~din_o;
        half();
        half();
    endtask
endmodule

// ===== sim/sarsc_top_chk.sv
// Port-level assertions of the converter serial control block.
`timescale 1ns/1ns
module sarsc_top_chk (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic cs_n_i,
    input wire logic dout_oe_o,
    input wire logic busy_o,
    input wire sarsc_pkg::sarsc_mux_t mux_o,
    input wire logic acquire_o,
    input wire logic converter_on_o,
    input wire logic [15:0] result_data_o,
    input wire logic result_valid_o,
    input wire logic result_ready_i
);
    import sarsc_pkg::*;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence s_hold; $fell(acquire_o) && !cs_n_i; endsequence
    sequence s_ext_start; s_hold ##[1:8] $rose(busy_o); endsequence
    property p_float; cs_n_i [*5] |-> !dout_oe_o; endproperty
    a_float: assert property (p_float) else $error("dout driven while deselected");
    property p_drive; (!cs_n_i) [*5] |-> dout_oe_o; endproperty
    a_drive: assert property (p_drive) else $error("dout not driven when selected");
    property p_on_hold; s_hold |-> converter_on_o; endproperty
    a_on_hold: assert property (p_on_hold) else $error("core off at hold");
    property p_busy_ext; s_ext_start |-> busy_o [*7] ##[1:2] !busy_o; endproperty
    a_busy_ext: assert property (p_busy_ext) else $error("status pulse length");
    property p_busy_int; s_hold ##1 !busy_o [*8] |-> ##[1:392] busy_o; endproperty
    a_busy_int: assert property (p_busy_int) else $error("internal conversion late");
    property p_se; mux_o.com_neg |-> mux_o.neg == 4'h0 && $onehot(mux_o.pos); endproperty
    a_se: assert property (p_se) else $error("single-ended mux wrong");
    property p_diff;
        !mux_o.com_neg && mux_o.pos != 4'h0 |-> $onehot(mux_o.pos) && $onehot(mux_o.neg)
            && (mux_o.pos | mux_o.neg) inside {4'h3, 4'hc};
    endproperty
    a_diff: assert property (p_diff) else $error("differential pair wrong");
    property p_fifo_hold;
        result_valid_o && !result_ready_i |=> result_valid_o && $stable(result_data_o);
    endproperty
    a_fifo_hold: assert property (p_fifo_hold) else $error("result lost");
endmodule
bind sarsc_top sarsc_top_chk u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i),
    .dout_oe_o(dout_oe_o), .busy_o(busy_o), .mux_o(mux_o), .acquire_o(acquire_o),
    .converter_on_o(converter_on_o), .result_data_o(result_data_o),
    .result_valid_o(result_valid_o), .result_ready_i(result_ready_i));

// ===== sim/sarsc_top_tb_top.sv
// Self-checking bench of the converter serial control block.
`timescale 1ns/1ns
module sarsc_top_tb_top;
    import sarsc_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic result_ready_i = 1'b0;
    logic [15:0] conv_code_i = 16'h0000;
    logic cs_n, sclk, din, dout, dout_oe, busy, busy_oe, acq, pwr, rvalid;
    logic [15:0] rdata;
    logic [15:0] code;
    logic [31:0] got;
    logic [15:0] q[$];
    logic [2:0] chs[4] = '{CH_CODE_0, CH_CODE_1, CH_CODE_2, CH_CODE_3};
    sarsc_mux_t mux;
    int bad_count = 0;
    int checked = 0;
    always #10 mclk_i = ~mclk_i;
    sarsc_top u_dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .shift_clock_i(sclk),
        .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .busy_o(busy), .busy_oe_o(busy_oe),
        .conv_code_i(conv_code_i), .mux_o(mux), .acquire_o(acq), .converter_on_o(pwr),
        .result_data_o(rdata), .result_valid_o(rvalid), .result_ready_i(result_ready_i)
    );
    sarsc_host u_host (
        .mclk_i(mclk_i), .dout_i(dout), .dout_oe_i(dout_oe),
        .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din)
    );
    task automatic end_of_test();
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic conv(input logic [7:0] cmd, input int lead, input int n,
                        input logic [15:0] c);
        conv_code_i <= c;
        q.push_back(c);
        u_host.frame({cmd, 24'h00_0000} >> lead, lead, n, got);
    endtask
    // The consumer stalls until four results wait, then empties the buffer.
    task automatic drain();
        #1;
        while (q.size() > 0) begin
            cmp(rvalid, 1'b1);
            cmp(rdata, q.pop_front());
            @(posedge mclk_i) result_ready_i <= 1'b1;
            @(posedge mclk_i) result_ready_i <= 1'b0;
            #1;
        end
        cmp(rvalid, 1'b0);
        @(posedge mclk_i);
    endtask
    initial begin
        #400000;
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        conv(8'h9c, 3, 27, 16'h7fff);
        cmp(got[15:0], 16'h7fff);
        repeat (8) @(posedge mclk_i);
        cmp(pwr, 1'b0);
        for (int k = 0; k < 8; k++) begin
            code = 16'h8000 ^ (16'h1337 * 16'(k));
            conv({1'b1, chs[k % 4], 1'b1, k < 4, PD_FULL}, 0, 24, code);
            cmp(got[15:0], code);
            cmp(mux, {4'(1 << k % 4), k < 4 ? 4'h0 : 4'(1 << (k % 4 ^ 1)), k < 4});
            if (q.size() == 4) drain();
        end
        cmp(pwr, 1'b1);
        code = 16'h2468;
        conv({1'b1, CH_CODE_1, 1'b1, 1'b0, PD_RSVD}, 0, 32, code);
        cmp(got[23:0], {code, 8'h00});
        u_host.deselect();
        cmp(dout_oe, 1'b0);
        u_host.frame(32'hd000_0000, 0, 4, got);
        u_host.deselect();
        code = 16'h8000;
        conv({1'b1, CH_CODE_2, 1'b1, 1'b1, PD_INTCLK}, 0, 24, code);
        cmp(got[15:0], code);
        cmp(mux, {4'h4, 4'h0, 1'b1});
        repeat (8) @(posedge mclk_i);
        cmp(pwr, 1'b0);
        code = 16'hc3a5;
        conv({1'b1, CH_CODE_3, 1'b1, 1'b0, PD_INTCLK}, 0, 8, code);
        u_host.deselect();
        cmp(busy_oe, 1'b1);
        cmp(busy, 1'b0);
        for (int w = 0; w < 450 && busy !== 1'b1; w++) @(posedge mclk_i);
        cmp(busy, 1'b1);
        cmp(dout_oe, 1'b0);
        u_host.frame(32'h0000_0000, -100, 16, got);
        cmp(got[15:0], code);
        cmp(mux, {4'h8, 4'h4, 1'b0});
        u_host.deselect();
        drain();
        end_of_test();
    end
endmodule
